/* core/serial_link_pkg.sv */
/*
  Shared constants for the RS-485 serial link block: clock rates, bit
  periods, gap timer thresholds, register indices, field positions and the
  state types of the receive and transmit engines.
  Assumes a single 100 MHz system clock feeding every module.
*/
package serial_link_pkg;
  // System clock rate in hertz.
  localparam int CLK_HZ = 100_000_000;
  // Bit rates of the two line profiles.
  localparam int FAST_BPS = 4_000_000;
  localparam int SLOW_BPS = 115_200;
  // Bit period in clock cycles; the slow rate is rounded to nearest, which
  // stands in for duty correction and keeps the error under 0.01 percent.
  localparam logic [15:0] BIT_CYC_FAST = 16'(CLK_HZ / FAST_BPS);
  localparam logic [15:0] BIT_CYC_SLOW = 16'((CLK_HZ + SLOW_BPS / 2) / SLOW_BPS);
  // Character framing.
  localparam int DATA_BITS = 8;
  // Gap timer tick rate and the divider that produces it.
  localparam int GAP_TICK_HZ = 500_000;
  localparam logic [7:0] GAP_DIV_CYC = 8'(CLK_HZ / GAP_TICK_HZ);
  // Idle thresholds in microseconds and in gap timer ticks.
  localparam int FRAME_GAP_US = 334;
  localparam int CHAR_GAP_US = 238;
  localparam logic [7:0] FRAME_GAP_TICKS = 8'(FRAME_GAP_US * GAP_TICK_HZ / 1_000_000);
  localparam logic [7:0] CHAR_GAP_TICKS = 8'(CHAR_GAP_US * GAP_TICK_HZ / 1_000_000);
  // Ring buffers used by the two byte movers.
  localparam int RING_BYTES = 512;
  localparam int RING_AW = 9;
  // Register indices; the byte address is four times the index.
  localparam logic [21:0] IDX_CTRL = 22'h08_a020;
  localparam logic [21:0] IDX_STATUS = 22'h08_a021;
  localparam logic [21:0] IDX_TX_COUNT = 22'h08_a022;
  localparam logic [21:0] IDX_TX_DATA = 22'h08_a023;
  localparam logic [21:0] IDX_RX_DATA = 22'h08_a025;
  localparam logic [21:0] IDX_GAP_CMP_A = 22'h08_a026;
  localparam logic [21:0] IDX_GAP_CMP_B = 22'h08_a027;
  localparam logic [21:0] IDX_GAP_COUNT = 22'h08_a028;
  localparam logic [21:0] IDX_RING_PTR = 22'h08_a029;
  localparam logic [21:0] IDX_RX_RING = 22'h08_a02a;
  localparam logic [21:0] IDX_TX_RING = 22'h08_a02b;
  // Control register fields.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PROFILE = 1;
  localparam int CTRL_ERR_IRQ = 3;
  localparam int CTRL_SER_PRIO_LSB = 8;
  localparam int CTRL_TMR_PRIO_LSB = 12;
  localparam logic [3:0] EVENT_PRIO = 4'h1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  // Status register fields.
  localparam int ST_RX_FULL = 0;
  localparam int ST_TX_EMPTY = 1;
  localparam int ST_TX_END = 2;
  localparam int ST_FRAME_GAP = 3;
  localparam int ST_CHAR_GAP = 4;
  localparam int ST_RX_ERR = 5;
  localparam int ST_DIR = 6;
  localparam int ST_TX_BUSY = 7;
  // Ring pointer register field.
  localparam int PTR_SW_LSB = 16;
  // Engine states.
  typedef enum logic [2:0] {LINE_IDLE, LINE_START, LINE_DATA, LINE_PARITY, LINE_STOP} line_state_t;

  // Ring pointer advance; wraps within the 512-byte ring by width alone.
  function automatic logic [RING_AW-1:0] ring_next(input logic [RING_AW-1:0] ptr);
    ring_next = ptr + 9'h001;
  endfunction
endpackage

/* core/serial_rx_engine.sv */
/*
  Receive engine: finds a start bit, samples eight data bits least
  significant first, an optional even parity bit and one stop bit.
  Assumes the line input is already synchronised to clk.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_rx_engine (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Line and its falling edge.
  input wire logic rx_bit,
  input wire logic rx_fall,
  // Configuration.
  input wire logic enable,
  input wire logic parity_en,
  input wire logic [15:0] bit_cycles,
  // Received character.
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_err
);
  // Engine state, bit timer, bit index, shifter and running parity.
  serial_link_pkg::line_state_t state;
  logic [15:0] cnt;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic par;
  logic par_err;
  // The bit timer expiring marks the sampling point of the current bit.
  wire expired = (cnt == 16'h0000);

  // Sampling happens mid-bit: the start bit is checked half a period after
  // the edge, so a short glitch drops back to idle instead of framing junk.
  always_ff @(posedge clk) begin
    byte_valid <= 1'b0;
    if (srst) begin
      state <= serial_link_pkg::LINE_IDLE;
      cnt <= 16'h0000;
      bitn <= 3'h0;
      shreg <= 8'h00;
      par <= 1'b0;
      par_err <= 1'b0;
      byte_data <= 8'h00;
      byte_err <= 1'b0;
    end else if (state != serial_link_pkg::LINE_IDLE && !expired) begin
      cnt <= cnt - 16'h0001;
    end else begin
      cnt <= bit_cycles - 16'h0001;
      case (state)
        serial_link_pkg::LINE_IDLE: begin
          // A character begins on a falling edge of the line.
          if (enable && rx_fall) begin
            state <= serial_link_pkg::LINE_START;
            cnt <= {1'b0, bit_cycles[15:1]};
          end
        end
        serial_link_pkg::LINE_START: begin
          // Line back high at mid-start means noise; ignore it.
          state <= rx_bit ? serial_link_pkg::LINE_IDLE : serial_link_pkg::LINE_DATA;
          bitn <= 3'h0;
          par <= 1'b0;
          par_err <= 1'b0;
        end
        serial_link_pkg::LINE_DATA: begin
          // Least significant bit arrives first.
          shreg <= {rx_bit, shreg[7:1]};
          par <= par ^ rx_bit;
          bitn <= bitn + 3'h1;
          if (bitn == 3'h7) begin
            state <= parity_en ? serial_link_pkg::LINE_PARITY : serial_link_pkg::LINE_STOP;
          end
        end
        serial_link_pkg::LINE_PARITY: begin
          // Even parity: data ones plus the parity bit must be even.
          par_err <= par ^ rx_bit;
          state <= serial_link_pkg::LINE_STOP;
        end
        serial_link_pkg::LINE_STOP: begin
          // One stop bit; a low stop bit is a framing error.
          byte_valid <= 1'b1;
          byte_data <= shreg;
          byte_err <= par_err | ~rx_bit;
          state <= serial_link_pkg::LINE_IDLE;
        end
        default: begin
          state <= serial_link_pkg::LINE_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/serial_tx_engine.sv */
/*
  Transmit engine: sends a start bit, eight data bits least significant
  first, an optional even parity bit and one stop bit.
  Assumes start is a one-cycle pulse given only while busy is low.
*/
`timescale 1ns/1ns
`default_nettype none
module serial_tx_engine (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // Character to send.
  input wire logic start,
  input wire logic [7:0] data,
  // Configuration.
  input wire logic parity_en,
  input wire logic [15:0] bit_cycles,
  // Line and progress.
  output logic txd,
  output logic busy,
  output logic done
);
  // Engine state, bit timer, bit index, shifter and parity bit.
  serial_link_pkg::line_state_t state;
  logic [15:0] cnt;
  logic [2:0] bitn;
  logic [7:0] shreg;
  logic par;
  // End of the current bit on the line.
  wire expired = (cnt == 16'h0000);

  // Each bit is held for bit_cycles clocks; the line idles high.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (srst) begin
      state <= serial_link_pkg::LINE_IDLE;
      cnt <= 16'h0000;
      bitn <= 3'h0;
      shreg <= 8'h00;
      par <= 1'b0;
      txd <= 1'b1;
      busy <= 1'b0;
    end else if (state == serial_link_pkg::LINE_IDLE) begin
      if (start) begin
        state <= serial_link_pkg::LINE_START;
        shreg <= data;
        par <= ^data;
        txd <= 1'b0;
        busy <= 1'b1;
        cnt <= bit_cycles - 16'h0001;
      end
    end else if (!expired) begin
      cnt <= cnt - 16'h0001;
    end else begin
      cnt <= bit_cycles - 16'h0001;
      case (state)
        serial_link_pkg::LINE_START: begin
          state <= serial_link_pkg::LINE_DATA;
          txd <= shreg[0];
          bitn <= 3'h0;
        end
        serial_link_pkg::LINE_DATA: begin
          bitn <= bitn + 3'h1;
          if (bitn == 3'h7) begin
            state <= parity_en ? serial_link_pkg::LINE_PARITY : serial_link_pkg::LINE_STOP;
            txd <= parity_en ? par : 1'b1;
          end else begin
            txd <= shreg[3'(bitn + 3'h1)];
          end
        end
        serial_link_pkg::LINE_PARITY: begin
          state <= serial_link_pkg::LINE_STOP;
          txd <= 1'b1;
        end
        serial_link_pkg::LINE_STOP: begin
          state <= serial_link_pkg::LINE_IDLE;
          busy <= 1'b0;
          done <= 1'b1;
        end
        default: begin
          state <= serial_link_pkg::LINE_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

/* core/rs485_async_serial_link.sv */
/*
  Top of the RS-485 serial link: APB register slave, transmit holding
  register, receive and transmit engines, two ring-buffer byte movers, the
  idle-gap timer and the line driver direction output.
  Assumes an APB master on clk and an asynchronous receive line.
  // Behaviour
  // - Async 8 data bits, LSB first, one stop.
  // - Falling edge on receive line starts a character.
  // - Internal baud; 4 Mbps plain, 115200 even parity.
  // - No error interrupt, filter or flow control.
  // - Serial events all carry priority level 1.
  // - Fast profile: receive full fills 512-byte ring.
  // - Fast profile: counted transmit drains 512-byte ring.
  // - Each move is one byte, clears its flag.
  // - Gap timer ticks 500 kHz, compare A 334 us.
  // - Compare B marks the shorter 238 us gap.
  // - Both compares flag at level 1; no overflow.
  // - Push-pull output steers the line driver.
  // - Gap timer finds receive and transmit frame ends.
*/
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module rs485_async_serial_link (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Serial line and driver direction.
  input wire logic serial_rx_line,
  output logic serial_tx_line,
  output logic driver_direction_pin
);
  // Receive line synchroniser; meta is read only by sync.
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  // Control bits: enable and profile (1 selects 115200 with even parity).
  logic ctrl_enable;
  logic ctrl_profile;
  // Event flags.
  logic rx_full_event;
  logic tx_empty_event;
  logic tx_end_event;
  logic frame_gap_flag;
  logic char_gap_flag;
  logic rx_err_flag;
  // Transmit holding register.
  logic [7:0] tx_hold;
  logic tx_hold_full;
  logic tx_start;
  // Ring buffers and their pointers.
  logic [7:0] rx_ring [serial_link_pkg::RING_BYTES];
  logic [7:0] tx_ring [serial_link_pkg::RING_BYTES];
  logic [8:0] rx_wr_ptr;
  logic [8:0] tx_rd_ptr;
  logic [8:0] sw_ptr;
  logic [9:0] tx_count;
  // Gap timer.
  logic [7:0] gap_div;
  logic [7:0] gap_counter;
  logic [7:0] frame_gap_compare;
  logic [7:0] char_gap_compare;
  // Engine outputs.
  wire rx_valid;
  wire [7:0] serial_rx_data;
  wire rx_bad;
  wire tx_busy;
  wire tx_done;

  // The line is seen through two flip-flops before any logic reads it.
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= serial_rx_line;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Profile selection: bit period and parity come from one control bit.
  wire [15:0] bit_cycles = ctrl_profile ? serial_link_pkg::BIT_CYC_SLOW
                                        : serial_link_pkg::BIT_CYC_FAST;
  wire parity_en = ctrl_profile;
  wire fast_mode = ctrl_enable & ~ctrl_profile;
  // Falling edge taken from the synchronised stages only.
  wire rx_fall = rx_prev & ~rx_sync;

  // Receive engine; no noise filter sits in front of it.
  serial_rx_engine u_rx (
    .clk(clk),
    .srst(srst),
    .rx_bit(rx_sync),
    .rx_fall(rx_fall),
    .enable(ctrl_enable),
    .parity_en(parity_en),
    .bit_cycles(bit_cycles),
    .byte_valid(rx_valid),
    .byte_data(serial_rx_data),
    .byte_err(rx_bad)
  );

  // Transmit engine, started from the holding register.
  serial_tx_engine u_tx (
    .clk(clk),
    .srst(srst),
    .start(tx_start),
    .data(tx_hold),
    .parity_en(parity_en),
    .bit_cycles(bit_cycles),
    .txd(serial_tx_line),
    .busy(tx_busy),
    .done(tx_done)
  );

  // APB decode: aligned word, index in the upper address bits.
  wire [21:0] idx = paddr[23:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_ctrl = aligned && idx == serial_link_pkg::IDX_CTRL;
  wire hit_status = aligned && idx == serial_link_pkg::IDX_STATUS;
  wire hit_count = aligned && idx == serial_link_pkg::IDX_TX_COUNT;
  wire hit_txd = aligned && idx == serial_link_pkg::IDX_TX_DATA;
  wire hit_rxd = aligned && idx == serial_link_pkg::IDX_RX_DATA;
  wire hit_cmpa = aligned && idx == serial_link_pkg::IDX_GAP_CMP_A;
  wire hit_cmpb = aligned && idx == serial_link_pkg::IDX_GAP_CMP_B;
  wire hit_gcnt = aligned && idx == serial_link_pkg::IDX_GAP_COUNT;
  wire hit_ptr = aligned && idx == serial_link_pkg::IDX_RING_PTR;
  wire hit_rxr = aligned && idx == serial_link_pkg::IDX_RX_RING;
  wire hit_txr = aligned && idx == serial_link_pkg::IDX_TX_RING;
  wire hit_any = hit_ctrl | hit_status | hit_count | hit_txd | hit_rxd | hit_cmpa
               | hit_cmpb | hit_gcnt | hit_ptr | hit_rxr | hit_txr;
  // A transfer completes at the edge where pready is high.
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite & hit_any;
  wire rd = acc & ~pwrite & hit_any;

  // Read data mux; priority fields read back as fixed level 1.
  wire [31:0] ctrl_word = {16'h0000, serial_link_pkg::EVENT_PRIO, serial_link_pkg::EVENT_PRIO,
                           4'h0, 1'b0, 1'b0, ctrl_profile, ctrl_enable};
  wire [31:0] status_word = {24'h00_0000, tx_busy, driver_direction_pin, rx_err_flag,
                             char_gap_flag, frame_gap_flag, tx_end_event, tx_empty_event,
                             rx_full_event};
  wire [31:0] rd_mux =
      hit_ctrl ? ctrl_word :
      hit_status ? status_word :
      hit_count ? {22'h00_0000, tx_count} :
      hit_rxd ? {24'h00_0000, serial_rx_data} :
      hit_cmpa ? {24'h00_0000, frame_gap_compare} :
      hit_cmpb ? {24'h00_0000, char_gap_compare} :
      hit_gcnt ? {24'h00_0000, gap_counter} :
      hit_ptr ? {7'h00, sw_ptr, 7'h00, rx_wr_ptr} :
      hit_rxr ? {24'h00_0000, rx_ring[sw_ptr]} :
      32'h0000_0000;

  // Two-cycle access: pready rises one cycle into the access phase.
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      prdata <= (psel & penable & ~pready & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr <= psel & penable & ~pready & ~hit_any;
    end
  end

  // Software writes of one-bit-clear flags and of the transmit data.
  wire sw_txd = wr & hit_txd;
  wire [31:0] w1c = (wr & hit_status) ? pwdata : 32'h0000_0000;
  // Movers run only in the fast profile and yield to software.
  wire rx_move = fast_mode & rx_full_event;
  wire tx_move = fast_mode & tx_empty_event & ~tx_hold_full & ~sw_txd
               & (tx_count != 10'h000);
  wire hold_load = sw_txd | tx_move;
  wire [7:0] hold_value = sw_txd ? pwdata[7:0] : tx_ring[tx_rd_ptr];
  // Shift out only once the driver already points outward.
  wire start_now = ctrl_enable & driver_direction_pin & tx_hold_full & ~tx_busy
                 & ~tx_start;
  wire end_now = tx_done & ~tx_hold_full & ~hold_load;

  // Control, pointers, rings and compare registers written by software or by the movers.
  always_ff @(posedge clk) begin
    if (srst) begin
      {ctrl_profile, ctrl_enable} <= serial_link_pkg::CTRL_RESET;
      sw_ptr <= 9'h000;
      tx_rd_ptr <= 9'h000;
      tx_count <= 10'h000;
      rx_wr_ptr <= 9'h000;
      frame_gap_compare <= serial_link_pkg::FRAME_GAP_TICKS;
      char_gap_compare <= serial_link_pkg::CHAR_GAP_TICKS;
    end else begin
      if (wr & hit_ctrl) begin
        ctrl_enable <= pwdata[serial_link_pkg::CTRL_ENABLE];
        ctrl_profile <= pwdata[serial_link_pkg::CTRL_PROFILE];
      end
      if (wr & hit_cmpa) begin
        frame_gap_compare <= pwdata[7:0];
      end
      if (wr & hit_cmpb) begin
        char_gap_compare <= pwdata[7:0];
      end
      // The window pointer advances on each receive ring read and transmit ring write.
      if (wr & hit_ptr) begin
        sw_ptr <= pwdata[serial_link_pkg::PTR_SW_LSB +: 9];
      end else if ((rd & hit_rxr) | (wr & hit_txr)) begin
        sw_ptr <= serial_link_pkg::ring_next(sw_ptr);
      end
      if (wr & hit_txr) begin
        tx_ring[sw_ptr] <= pwdata[7:0];
      end
      // Writing the count arms the transmit mover from the window pointer.
      if (wr & hit_count) begin
        tx_count <= pwdata[9:0];
        tx_rd_ptr <= sw_ptr;
      end else if (tx_move) begin
        tx_count <= tx_count - 10'h001;
        tx_rd_ptr <= serial_link_pkg::ring_next(tx_rd_ptr);
      end
      if (rx_move) begin
        rx_ring[rx_wr_ptr] <= serial_rx_data;
        rx_wr_ptr <= serial_link_pkg::ring_next(rx_wr_ptr);
      end
    end
  end

  // Holding register, engine start and line driver direction.
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_hold <= 8'h00;
      tx_hold_full <= 1'b0;
      tx_start <= 1'b0;
      driver_direction_pin <= 1'b0;
    end else begin
      tx_start <= start_now;
      if (hold_load) begin
        tx_hold <= hold_value;
        tx_hold_full <= 1'b1;
      end else if (start_now) begin
        tx_hold_full <= 1'b0;
      end
      // Direction goes out with the first load and back after the end.
      if (hold_load) begin
        driver_direction_pin <= 1'b1;
      end else if (end_now) begin
        driver_direction_pin <= 1'b0;
      end
    end
  end

  // Event flags; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      rx_full_event <= 1'b0;
      tx_empty_event <= 1'b1;
      tx_end_event <= 1'b1;
      rx_err_flag <= 1'b0;
    end else begin
      // Cleared by the mover or by software reading received data.
      if (rx_valid) begin
        rx_full_event <= 1'b1;
      end else if (rx_move | (rd & hit_rxd)) begin
        rx_full_event <= 1'b0;
      end
      if (start_now) begin
        tx_empty_event <= 1'b1;
      end else if (hold_load) begin
        tx_empty_event <= 1'b0;
      end
      if (end_now) begin
        tx_end_event <= 1'b1;
      end else if (hold_load) begin
        tx_end_event <= 1'b0;
      end
      // Errors are only recorded; no interrupt path exists for them.
      if (rx_valid & rx_bad) begin
        rx_err_flag <= 1'b1;
      end else if (w1c[serial_link_pkg::ST_RX_ERR]) begin
        rx_err_flag <= 1'b0;
      end
    end
  end

  // Gap timer tick: one-cycle enable at 500 kHz.
  wire gap_tick = (gap_div == 8'h00);
  wire [7:0] gap_next = 8'(gap_counter + 8'h01);
  // A received character or the end of a transmission restarts the count.
  wire gap_restart = rx_valid | end_now;
  wire frame_hit = gap_tick & ~gap_restart & (gap_next == frame_gap_compare);
  wire char_hit = gap_tick & ~gap_restart & (gap_next == char_gap_compare);

  // The counter never clears itself on a match and wraps silently, since
  // overflow is of no interest to the frame logic.
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_div <= 8'h00;
      gap_counter <= 8'h00;
      frame_gap_flag <= 1'b0;
      char_gap_flag <= 1'b0;
    end else begin
      gap_div <= gap_tick ? 8'(serial_link_pkg::GAP_DIV_CYC - 8'h01)
                          : gap_div - 8'h01;
      if (gap_restart) begin
        gap_counter <= 8'h00;
      end else if (gap_tick) begin
        gap_counter <= gap_next;
      end
      if (frame_hit) begin
        frame_gap_flag <= 1'b1;
      end else if (w1c[serial_link_pkg::ST_FRAME_GAP]) begin
        frame_gap_flag <= 1'b0;
      end
      if (char_hit) begin
        char_gap_flag <= 1'b1;
      end else if (w1c[serial_link_pkg::ST_CHAR_GAP]) begin
        char_gap_flag <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/rs485_link_asserts.sv */
/* Checker for the serial link top: APB timing and line direction.
   Assumes it is bound to the top and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module rs485_link_asserts (
  // Clock and reset.
  input wire logic clk,
  input wire logic srst,
  // APB slave pins.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Line pins.
  input wire logic serial_rx_line,
  input wire logic serial_tx_line,
  input wire logic driver_direction_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // The slave answers after exactly one wait state.
  a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("late pready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_err_unaligned: assert property (psel && !penable && paddr[1:0] != 2'b00 |-> ##2 pslverr)
    else $error("unaligned accepted");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata stale");
  // A receiving node must leave the bus idle high.
  a_idle_high:
    assert property (!driver_direction_pin |-> serial_tx_line)
    else $error("line low while receiving");
  a_dir_leads:
    assert property ($rose(driver_direction_pin) |-> ##[1:4] $fell(serial_tx_line))
    else $error("no start after direction");
  a_dir_trails:
    assert property ($fell(driver_direction_pin) |-> $past(serial_tx_line, 8))
    else $error("direction dropped early");
  // The shortest bit period is 25 cycles.
  a_start_len:
    assert property ($fell(serial_tx_line) |-> (!serial_tx_line)[*8] ##17 !serial_tx_line)
    else $error("start bit short");
endmodule
bind rs485_async_serial_link rs485_link_asserts chk (.clk(clk), .srst(srst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .serial_rx_line(serial_rx_line),
  .serial_tx_line(serial_tx_line), .driver_direction_pin(driver_direction_pin));
`default_nettype wire

/* tb/serial_host_model.sv */
/* Serial host at the far end of the RS-485 line.
   Assumes the bench calls its tasks; the line idles high. */
`timescale 1ns/1ns
`default_nettype none
module serial_host_model (
  // Bit timing clock.
  input wire logic clk,
  // Line from and to the device, and the device's driver enable.
  input wire logic tx_line,
  input wire logic drv_en,
  output logic rx_line
);
  // With the device's driver off the line rests at its idle-high bias.
  wire line = drv_en ? tx_line : 1'b1;
  initial rx_line = 1'b1;
  // Start, eight bits LSB first, optional even parity, one stop.
  task automatic send(input logic [7:0] d, input logic par, input int cyc);
    logic [10:0] f;
    f = par ? {1'b1, ^d, d, 1'b0} : {2'b11, d, 1'b0};
    for (int i = 0; i < 10 + int'(par); i++) begin
      rx_line <= f[i];
      repeat (cyc) @(posedge clk);
    end
  endtask
  // Samples the eight data bits of one frame at mid-bit.
  task automatic recv(input int cyc, output logic [7:0] d);
    @(negedge line);
    repeat (cyc / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (cyc) @(posedge clk);
      d[i] = line;
    end
  endtask
endmodule
`default_nettype wire

/* tb/rs485_async_serial_link_bench.sv */
/* Bench for the serial link: APB tasks and a host on the line.
   Assumes the package, host model and checker are compiled first. */
`timescale 1ns/1ns
`default_nettype none
module rs485_async_serial_link_bench;
  // Bench-driven inputs, defined at time zero.
  logic clk = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [23:0] paddr = 24'h00_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  // Design outputs and captured values.
  logic pready, pslverr, rx_line, tx_line, dir, err;
  logic [31:0] prdata, rd;
  logic [7:0] got;
  int fail_count = 0, checks = 0, cyc = 0;
  rs485_async_serial_link dut (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .serial_rx_line(rx_line), .serial_tx_line(tx_line),
    .driver_direction_pin(dir));
  serial_host_model host (.clk(clk), .tx_line(tx_line), .drv_en(dir), .rx_line(rx_line));
  initial forever #5 clk = ~clk;
  // One APB transfer; lo offsets the byte address for misuse.
  task automatic apb(input logic w, input logic [21:0] idx, input logic [31:0] d,
    input logic [1:0] lo = 2'b00);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, lo};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // The sequence needs about 60000 cycles; a hang ends here.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, serial_link_pkg::IDX_CTRL, 32'h0);
    chk("ctrl", 32'h0000_1100, rd);
    apb(1'b0, serial_link_pkg::IDX_STATUS, 32'h0);
    chk("status", 32'h0000_0006, rd);
    apb(1'b0, serial_link_pkg::IDX_GAP_CMP_A, 32'h0);
    chk("cmp a", 32'h0000_00a7, rd);
    apb(1'b0, serial_link_pkg::IDX_GAP_CMP_B, 32'h0);
    chk("cmp b", 32'h0000_0077, rd);
    apb(1'b0, serial_link_pkg::IDX_CTRL, 32'h0, 2'b10);
    chk("unaligned", 32'h0000_0001, {31'h0, err});
    apb(1'b1, serial_link_pkg::IDX_CTRL, 32'h0000_ff09);
    apb(1'b0, serial_link_pkg::IDX_CTRL, 32'h0);
    chk("ctrl fixed", 32'h0000_1101, rd);
    fork
      apb(1'b1, serial_link_pkg::IDX_TX_DATA, 32'h0000_003c);
      host.recv(25, got);
    join
    chk("tx byte", 32'h0000_003c, {24'h0, got});
    chk("dir tx", 32'h0000_0001, {31'h0, dir});
    repeat (100) @(posedge clk);
    chk("dir rx", 32'h0, {31'h0, dir});
    host.send(8'ha5, 1'b0, 25);
    repeat (10) @(posedge clk);
    apb(1'b0, serial_link_pkg::IDX_RX_RING, 32'h0);
    chk("rx ring", 32'h0000_00a5, rd);
    apb(1'b0, serial_link_pkg::IDX_STATUS, 32'h0);
    chk("rx full", 32'h0, rd & 32'h1);
    apb(1'b1, serial_link_pkg::IDX_TX_RING, 32'h0000_0081);
    apb(1'b1, serial_link_pkg::IDX_RING_PTR, 32'h0001_0000);
    fork
      apb(1'b1, serial_link_pkg::IDX_TX_COUNT, 32'h0000_0001);
      host.recv(25, got);
    join
    chk("tx mover", 32'h0000_0081, {24'h0, got});
    repeat (100) @(posedge clk);
    apb(1'b1, serial_link_pkg::IDX_CTRL, 32'h0000_0003);
    host.send(8'h5b, 1'b1, 868);
    apb(1'b0, serial_link_pkg::IDX_RX_DATA, 32'h0);
    chk("slow rx", 32'h0000_005b, rd);
    apb(1'b0, serial_link_pkg::IDX_STATUS, 32'h0);
    chk("parity", 32'h0, rd & 32'h20);
    // Clear stale gap flags; the counter restarted on the byte.
    apb(1'b1, serial_link_pkg::IDX_STATUS, 32'h0000_0038);
    repeat (26000) @(posedge clk);
    apb(1'b0, serial_link_pkg::IDX_STATUS, 32'h0);
    chk("char gap", 32'h0000_0010, rd & 32'h18);
    repeat (9000) @(posedge clk);
    apb(1'b0, serial_link_pkg::IDX_STATUS, 32'h0);
    chk("frame gap", 32'h0000_0018, rd & 32'h18);
    // Even data with no parity bit: the stop bit lands as a wrong parity.
    host.send(8'h5a, 1'b0, 868);
    repeat (1000) @(posedge clk);
    apb(1'b0, serial_link_pkg::IDX_STATUS, 32'h0);
    chk("rx err", 32'h0000_0020, rd & 32'h20);
    complete_run();
  end
endmodule
`default_nettype wire
